// ---- verilog/sdbm_core.v ----
// Burst and row-activation core of one four-bank SDRAM device.
// Assumes commands are synchronous to sys_clk_in and issued legally.
// Write data passes through a FIFO into the bank array.
`include "sdbm_consts.vh"
module sdbm_core (
    // Clock and reset
    input wire sys_clk_in,
    input wire srst_in,
    // Command pins
    input wire cs_n_in,
    input wire ras_n_in,
    input wire cas_n_in,
    input wire we_n_in,
    input wire [1:0] bank_in,
    input wire [`SDBM_ROW_W-1:0] addr_in,
    // Data pins
    input wire [`SDBM_DQ_W-1:0] dq_in,
    output reg [`SDBM_DQ_W-1:0] dq_out,
    output reg dq_oe_out,
    // Status
    output reg [`SDBM_MODE_W-1:0] operating_configuration_out,
    output reg normal_mode_out,
    output reg [3:0] bank_open_out,
    output reg wr_stall_out
);
    localparam ST_IDLE = 2'h0; // No burst
    localparam ST_RD = 2'h1; // Read burst
    localparam ST_WR = 2'h2; // Write burst
    reg [1:0] state; // Burst state
    reg [`SDBM_MODE_W-1:0] mode; // Mode register
    reg [`SDBM_ROW_W-1:0] open_row [0:3]; // Row held open per bank
    reg [15:0] mem [0:1023]; // Small array, row LSB, bank LSB and column
    reg [1:0] cur_bank; // Bank of current burst
    reg [`SDBM_COL_W-1:0] start_col; // Start column of burst
    reg [7:0] beat; // Beat count in burst
    reg [8:0] len; // Beats in burst, 256 in full page
    reg fp; // Full page burst runs until stopped
    reg [2:0] rd_pipe; // Read data stage valid
    reg [`SDBM_DQ_W-1:0] rd_d0; // Read pipeline data
    reg [`SDBM_DQ_W-1:0] rd_d1;
    reg [9:0] wr_addr_q; // Unused; arr_addr goes into the FIFO with the write word
    reg [`SDBM_DQ_W-1:0] wr_data_q; // Data pins as seen at the previous edge
    wire [2:0] burst_size_field;
    wire [2:0] read_latency_field;
    wire ordering_type_bit;
    wire operating_mode_bit_low;
    wire operating_mode_bit_high;
    wire single_write_option_bit;
    wire [3:0] cmd;
    wire [`SDBM_COL_W-1:0] col;
    wire [9:0] arr_addr;
    wire fifo_wr_ready;
    wire fifo_rd_valid;
    wire [25:0] fifo_rd_data;
    wire fifo_push;
    reg [8:0] next_len;
    assign burst_size_field = mode[`SDBM_BL_MSB:`SDBM_BL_LSB];
    assign read_latency_field = mode[`SDBM_CL_MSB:`SDBM_CL_LSB];
    assign ordering_type_bit = mode[`SDBM_ORD_BIT];
    assign operating_mode_bit_low = mode[`SDBM_OPM_LO];
    assign operating_mode_bit_high = mode[`SDBM_OPM_HI];
    assign single_write_option_bit = mode[`SDBM_SWR_BIT];
    assign cmd = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
    // Column of the beat in progress
    sdbm_col_gen u_col (
        .start_col_in(start_col),
        .beat_in(beat),
        .burst_size_field_in(burst_size_field),
        .ordering_type_bit_in(ordering_type_bit),
        .col_out(col)
    );
    // Array index mixes bank LSB, one row LSB and column
    assign arr_addr = {open_row[cur_bank][0], cur_bank[0], col};
    // Write words buffered before the array; the drain is free-running
    // but the fill can stall so occupancy is honest
    assign fifo_push = (state == ST_WR) && normal_mode_out;
    sdbm_fifo #(
        .WIDTH(26),
        .DEPTH(`SDBM_FIFO_DEPTH),
        .AW(5)
    ) u_fifo (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .wr_valid_in(fifo_push),
        .wr_ready_out(fifo_wr_ready),
        .wr_data_in({arr_addr, wr_data_q}),
        .rd_valid_out(fifo_rd_valid),
        .rd_ready_in(1'b1),
        .rd_data_out(fifo_rd_data)
    );
    // Burst length from the size field, writes maybe forced to one
    always @*
    begin
        case (burst_size_field)
            `SDBM_BL_1: next_len = 9'h001;
            `SDBM_BL_2: next_len = 9'h002;
            `SDBM_BL_4: next_len = 9'h004;
            `SDBM_BL_8: next_len = 9'h008;
            `SDBM_BL_FP: next_len = 9'h100;
            default: next_len = 9'h001; // Reserved code, treated as one
        endcase
        if ((cmd == `SDBM_CMD_WR) && single_write_option_bit)
        begin
            next_len = 9'h001;
        end
    end
    // Mode register load and row activation
    always @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            mode <= `SDBM_MODE_RST;
            bank_open_out <= 4'h0;
            open_row[0] <= 12'h000;
            open_row[1] <= 12'h000;
            open_row[2] <= 12'h000;
            open_row[3] <= 12'h000;
        end
        else
        begin
            case (cmd)
                `SDBM_CMD_MRS:
                begin
                    mode <= addr_in;
                end
                `SDBM_CMD_ACT:
                begin
                    // Bank and row both carried by the activate
                    open_row[bank_in] <= addr_in;
                    bank_open_out[bank_in] <= 1'b1;
                end
                `SDBM_CMD_PRE:
                begin
                    // Address bit ten closes every bank
                    if (addr_in[10])
                    begin
                        bank_open_out <= 4'h0;
                    end
                    else
                    begin
                        bank_open_out[bank_in] <= 1'b0;
                    end
                end
                default:
                begin
                    bank_open_out <= bank_open_out;
                end
            endcase
        end
    end
    // Burst sequencer: a new read/write truncates any burst in flight
    always @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            state <= ST_IDLE;
            cur_bank <= 2'h0;
            start_col <= 8'h00;
            beat <= 8'h00;
            len <= 9'h001;
            fp <= 1'b0;
        end
        else if ((cmd == `SDBM_CMD_RD) || (cmd == `SDBM_CMD_WR))
        begin
            state <= (cmd == `SDBM_CMD_RD) ? ST_RD : ST_WR;
            cur_bank <= bank_in;
            start_col <= addr_in[`SDBM_COL_W-1:0];
            beat <= 8'h00;
            len <= next_len;
            fp <= (next_len == 9'h100);
        end
        else if ((cmd == `SDBM_CMD_BST) || (cmd == `SDBM_CMD_PRE))
        begin
            state <= ST_IDLE;
        end
        else if (state != ST_IDLE)
        begin
            if (!fp && ({1'b0, beat} + 9'h001 >= len))
            begin
                state <= ST_IDLE;
            end
            else
            begin
                // Full page keeps going and wraps in the row
                beat <= beat + 8'h01;
            end
        end
    end
    // First write beat is sampled with the command itself; the state only
    // says write one edge later, so the word is held back by one edge
    always @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            wr_data_q <= 16'h0000;
        end
        else
        begin
            wr_data_q <= dq_in;
        end
    end
    // Fill side full flag, registered for the status pin
    always @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            wr_stall_out <= 1'b0;
        end
        else
        begin
            wr_stall_out <= !fifo_wr_ready;
        end
    end
    // Array writes drain from the FIFO
    always @(posedge sys_clk_in)
    begin
        if (fifo_rd_valid)
        begin
            mem[fifo_rd_data[25:16]] <= fifo_rd_data[15:0];
        end
    end
    // Read pipeline: stage 0 fetch, extra stage for latency three
    always @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            rd_pipe <= 3'h0;
            rd_d0 <= 16'h0000;
            rd_d1 <= 16'h0000;
        end
        else
        begin
            rd_pipe[0] <= (state == ST_RD) && normal_mode_out;
            rd_d0 <= mem[arr_addr];
            rd_pipe[1] <= rd_pipe[0];
            rd_d1 <= rd_d0;
            rd_pipe[2] <= rd_pipe[1];
        end
    end
    // Drive pins: enable rises with the first word and holds a cycle past the last
    always @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            dq_out <= 16'h0000;
            dq_oe_out <= 1'b0;
        end
        else if (read_latency_field == `SDBM_CL_3)
        begin
            dq_out <= rd_d0;
            dq_oe_out <= rd_pipe[0] | rd_pipe[1];
        end
        else
        begin
            // Latency two: data out one stage sooner
            dq_out <= mem[arr_addr];
            dq_oe_out <= ((state == ST_RD) && normal_mode_out) | rd_pipe[0];
        end
    end
    // Status mirrors
    always @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            operating_configuration_out <= `SDBM_MODE_RST;
            normal_mode_out <= 1'b1;
        end
        else
        begin
            operating_configuration_out <= mode;
            // Test modes suppress all data movement
            normal_mode_out <= !operating_mode_bit_low && !operating_mode_bit_high;
        end
    end
endmodule // sdbm_core

// ---- verilog/sdbm_consts.vh ----
// Constants for the burst-mode and row-activation core of a four-bank SDRAM.
// Assumes commands are decoded from the usual select/strobe pins on sys_clk_in.
// Functional notes
// - Burst 1,2,4,8; full page sequential only
// - Burst stays inside aligned column group
// - Group chosen by upper column address bits
// - Low column bits give starting location
// - Full page increments and wraps in row
// - One mode bit picks burst ordering
// - Sequential adds, interleaved XORs beat count
// - Read latency two or three clocks
// - Data pins driven with first word, held one cycle after
// - Normal mode needs both mode bits zero
// - Option bit makes writes single location
// - Other-bank activates kept apart
// - Latency field bits four to six
`ifndef SDBM_CONSTS_VH
`define SDBM_CONSTS_VH
// Mode word field positions
`define SDBM_BL_LSB 0
`define SDBM_BL_MSB 2
`define SDBM_ORD_BIT 3
`define SDBM_CL_LSB 4
`define SDBM_CL_MSB 6
`define SDBM_OPM_LO 7
`define SDBM_OPM_HI 8
`define SDBM_SWR_BIT 9
`define SDBM_MODE_W 12
`define SDBM_MODE_RST 12'h020
// Burst length codes
`define SDBM_BL_1 3'h0
`define SDBM_BL_2 3'h1
`define SDBM_BL_4 3'h2
`define SDBM_BL_8 3'h3
`define SDBM_BL_FP 3'h7
// Latency codes
`define SDBM_CL_2 3'h2
`define SDBM_CL_3 3'h3
// Command encodings {cs_n, ras_n, cas_n, we_n}
`define SDBM_CMD_MRS 4'h0
`define SDBM_CMD_ACT 4'h3
`define SDBM_CMD_RD 4'h5
`define SDBM_CMD_WR 4'h4
`define SDBM_CMD_BST 4'h6
`define SDBM_CMD_PRE 4'h2
// Geometry
`define SDBM_COL_W 8
`define SDBM_ROW_W 12
`define SDBM_DQ_W 16
`define SDBM_FIFO_DEPTH 32
`endif

// ---- verilog/sdbm_fifo.v ----
// Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-high reset.
module sdbm_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    // Clock and reset
    input wire sys_clk_in,
    input wire srst_in,
    // Fill side
    input wire wr_valid_in,
    output wire wr_ready_out,
    input wire [WIDTH-1:0] wr_data_in,
    // Drain side
    output wire rd_valid_out,
    input wire rd_ready_in,
    output wire [WIDTH-1:0] rd_data_out
);
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage array
    reg [AW-1:0] wr_ptr; // Write index
    reg [AW-1:0] rd_ptr; // Read index
    reg [AW:0] count; // Occupancy, one bit wider for full
    wire push;
    wire pop;
    assign wr_ready_out = (count != DEPTH[AW:0]);
    assign rd_valid_out = (count != {(AW+1){1'b0}});
    assign rd_data_out = mem[rd_ptr];
    assign push = wr_valid_in && wr_ready_out;
    assign pop = rd_valid_out && rd_ready_in;
    // Storage write, no reset needed on data
    always @(posedge sys_clk_in)
    begin
        if (push)
        begin
            mem[wr_ptr] <= wr_data_in;
        end
    end
    // Pointers and occupancy
    always @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // sdbm_fifo

// ---- verilog/sdbm_col_gen.v ----
// Column sequencer: turns start column, beat count and mode into a column.
// Purely combinational; the caller owns the beat counter.
`include "sdbm_consts.vh"
module sdbm_col_gen (
    // Burst setup
    input wire [`SDBM_COL_W-1:0] start_col_in,
    input wire [7:0] beat_in,
    input wire [2:0] burst_size_field_in,
    input wire ordering_type_bit_in,
    // Resulting column
    output reg [`SDBM_COL_W-1:0] col_out
);
    reg [2:0] mask; // Low bits that move inside the group
    reg [2:0] low; // Position inside the group
    // Pick group size and ordering
    always @*
    begin
        case (burst_size_field_in)
            `SDBM_BL_2: mask = 3'h1;
            `SDBM_BL_4: mask = 3'h3;
            `SDBM_BL_8: mask = 3'h7;
            default: mask = 3'h0;
        endcase
        if (ordering_type_bit_in)
        begin
            low = start_col_in[2:0] ^ beat_in[2:0];
        end
        else
        begin
            low = start_col_in[2:0] + beat_in[2:0];
        end
        if (burst_size_field_in == `SDBM_BL_FP)
        begin
            // Full page wraps naturally in eight bits
            col_out = start_col_in + beat_in;
        end
        else
        begin
            // Upper bits fixed, low bits wrap in group
            col_out = (start_col_in & ~{5'h00, mask}) | {5'h00, low & mask};
        end
    end
endmodule // sdbm_col_gen

// ---- tb/sdbm_core_checker.sv ----
// Port-timing assertions for the burst and row-activation core.
// Assumes the controller leaves gaps between bursts and mode loads.
`include "sdbm_consts.vh"
module sdbm_core_checker (
    // Clock and reset
    input wire sys_clk_in,
    input wire srst_in,
    // Command pins
    input wire cs_n_in,
    input wire ras_n_in,
    input wire cas_n_in,
    input wire we_n_in,
    input wire [1:0] bank_in,
    input wire [11:0] addr_in,
    // Data pin enable and status
    input wire dq_oe_out,
    input wire [11:0] operating_configuration_out,
    input wire normal_mode_out,
    input wire [3:0] bank_open_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    wire [3:0] cmd = {cs_n_in, ras_n_in, cas_n_in, we_n_in}; // Decoded command
    wire rd = (cmd == `SDBM_CMD_RD);
    wire mrs = (cmd == `SDBM_CMD_MRS);
    wire act = (cmd == `SDBM_CMD_ACT);
    wire [2:0] lat = operating_configuration_out[6:4]; // Current read latency
    wire rd_idle = rd && !dq_oe_out && normal_mode_out; // Read from a quiet bus
    chk_mode_load: assert property (mrs |-> ##2 operating_configuration_out == $past(addr_in, 2))
        else $error("mode word not captured");
    chk_normal_flag: assert property (mrs |-> ##2 normal_mode_out == ($past(addr_in[8:7], 2) == 2'h0))
        else $error("normal flag wrong");
    chk_drive_two: assert property (rd_idle && lat == 3'h2 |-> ##1 !dq_oe_out ##1 dq_oe_out)
        else $error("drive start wrong at latency two");
    chk_drive_three: assert property (rd_idle && lat == 3'h3 |-> ##2 !dq_oe_out ##1 dq_oe_out)
        else $error("drive start wrong at latency three");
    chk_hold_burst: assert property (rd_idle && lat == 3'h2 && operating_configuration_out[2:0] == 3'h2
        |-> ##2 dq_oe_out [*4])
        else $error("drive dropped inside burst");
    chk_test_quiet: assert property (rd && !normal_mode_out |=> !dq_oe_out [*3])
        else $error("read served in test mode");
    chk_bank_open: assert property (act |=> bank_open_out[$past(bank_in)])
        else $error("bank not marked open");
    chk_reset_state: assert property (disable iff (1'b0) srst_in |=> !dq_oe_out
        && bank_open_out == 4'h0 && operating_configuration_out == `SDBM_MODE_RST)
        else $error("reset state wrong");
    cov_read_three: cover property (rd_idle && lat == 3'h3);
    cov_mode_load: cover property (mrs);
    cov_activate: cover property (act);
endmodule // sdbm_core_checker
bind sdbm_core sdbm_core_checker u_chk (.sys_clk_in, .srst_in, .cs_n_in, .ras_n_in, .cas_n_in,
    .we_n_in, .bank_in, .addr_in, .dq_oe_out, .operating_configuration_out, .normal_mode_out,
    .bank_open_out);

// ---- tb/sdbm_ctl_model.sv ----
// Memory controller model driving the command and write-data pins.
// Assumes the bench calls its tasks; pins change on falling edges only.
`include "sdbm_consts.vh"
module sdbm_ctl_model #(
    parameter int TRCD = 3, // Activate to read/write, in clocks
    parameter int TRP = 3 // Precharge to next command, in clocks
) (
    // Clock
    input wire sys_clk_in,
    // Command and data pins
    output logic cs_n_out,
    output logic ras_n_out,
    output logic cas_n_out,
    output logic we_n_out,
    output logic [1:0] bank_out,
    output logic [11:0] addr_out,
    output logic [15:0] dq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Deselected until the first command
    initial
    begin
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hF;
        bank_out = 2'h0;
        addr_out = 12'h000;
        dq_out = 16'h0000;
    end
    // One command for one edge; the task inverts the data pins at both falling edges
    task automatic cmd(input logic [3:0] code, input logic [1:0] bank, input logic [11:0] addr);
        @(negedge sys_clk_in);
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = code;
        bank_out = bank;
        addr_out = addr;
        dq_out = ~dq_out;
        @(negedge sys_clk_in);
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hF;
        dq_out = ~dq_out;
    endtask
    // Mode loads only with all banks closed, then row 0 of bank 0 is opened
    task automatic setup(input logic [11:0] word);
        cmd(`SDBM_CMD_PRE, 2'h0, 12'h400);
        repeat (TRP) @(negedge sys_clk_in);
        cmd(`SDBM_CMD_MRS, 2'h0, word);
        cmd(`SDBM_CMD_ACT, 2'h0, 12'h000);
        repeat (TRCD) @(negedge sys_clk_in);
    endtask
    // Stream one word per edge from col, then stop; arbitrary lengths need the stop
    task automatic wr(input int col, input int n, input logic [15:0] base);
        for (int k = 0; k < n; k++)
        begin
            @(negedge sys_clk_in);
            {cs_n_out, ras_n_out, cas_n_out, we_n_out} = (k == 0) ? `SDBM_CMD_WR : 4'hF;
            addr_out = 12'(col);
            dq_out = base + 16'((col + k) % 256);
        end
        cmd(`SDBM_CMD_BST, 2'h0, 12'h000);
    endtask
endmodule // sdbm_ctl_model

// ---- tb/test_sdbm_core.sv ----
// Self-checking bench for the burst and row-activation core.
// Assumes the controller model owns every command and data pin.
`include "sdbm_consts.vh"
module test_sdbm_core;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic srst = 1'b1; // Held for the first eight cycles
    wire cs_n, ras_n, cas_n, we_n, dq_oe, normal, stall;
    wire [1:0] bank;
    wire [11:0] addr, cfg;
    wire [15:0] dq_w, dq_r;
    wire [3:0] open_b;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [11:0] word;
    logic [15:0] exp_mem [0:255]; // Expected contents of row 0, bank 0
    // Length code, interleave, latency, start column
    int plan [6][4] = '{'{1, 0, 2, 9}, '{2, 0, 2, 5}, '{2, 1, 3, 5}, '{3, 1, 3, 13},
        '{3, 0, 2, 14}, '{0, 0, 3, 7}};
    always #10 sys_clk = ~sys_clk;
    sdbm_ctl_model ctl (.sys_clk_in(sys_clk), .cs_n_out(cs_n), .ras_n_out(ras_n),
        .cas_n_out(cas_n), .we_n_out(we_n), .bank_out(bank), .addr_out(addr), .dq_out(dq_w));
    sdbm_core dut (.sys_clk_in(sys_clk), .srst_in(srst), .cs_n_in(cs_n), .ras_n_in(ras_n),
        .cas_n_in(cas_n), .we_n_in(we_n), .bank_in(bank), .addr_in(addr), .dq_in(dq_w),
        .dq_out(dq_r), .dq_oe_out(dq_oe), .operating_configuration_out(cfg),
        .normal_mode_out(normal), .bank_open_out(open_b), .wr_stall_out(stall));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
            fail_count++;
        end
    endtask
    task automatic results();
        $display("checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Column of beat k: wraps inside the aligned group, or the whole row
    function automatic int colf(int start, int k, int len, int il);
        int o;
        if (len == 256)
            return (start + k) % 256;
        o = il ? ((start % len) ^ k) : ((start + k) % len);
        return start - (start % len) + o;
    endfunction
    // Read n beats; drive must be on at the same edge as the first word
    task automatic rd(input int start, input int len, input int n, input int il, input int lat);
        ctl.cmd(`SDBM_CMD_RD, 2'h0, 12'(start));
        repeat (lat - 1) @(negedge sys_clk);
        check("drive", {15'h0000, dq_oe}, 16'h0001);
        // Word k stands from the drive edge plus k up to the next edge
        for (int k = 0; k < n; k++)
        begin
            check("read word", dq_r, exp_mem[colf(start, k, len, il)]);
            @(negedge sys_clk);
        end
    endtask
    // Cut a hang short; the sequence needs well under 1500 cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fail_count++;
            results();
        end
    end
    initial
    begin
        for (int c = 0; c < 256; c++)
            exp_mem[c] = 16'hA000 + 16'(c);
        repeat (8) @(negedge sys_clk);
        srst = 1'b0;
        check("mode", {4'h0, cfg}, {4'h0, `SDBM_MODE_RST});
        check("open", {12'h000, open_b}, 16'h0000);
        check("normal", {15'h0000, normal}, 16'h0001);
        // Full page write across the row end, then a wrapping full page read
        ctl.setup(12'h027);
        check("open", {12'h000, open_b}, 16'h0001);
        ctl.wr(248, 24, 16'hA000);
        check("stall", {15'h0000, stall}, 16'h0000);
        rd(254, 256, 6, 0, 2);
        ctl.cmd(`SDBM_CMD_BST, 2'h0, 12'h000);
        // Every fixed length, with both orderings and both latencies at four and eight
        foreach (plan[i])
        begin
            word = 12'((plan[i][2] << 4) | (plan[i][1] << 3) | plan[i][0]);
            ctl.setup(word);
            check("mode", {4'h0, cfg}, {4'h0, word});
            rd(plan[i][3], 1 << plan[i][0], 1 << plan[i][0], plan[i][1], plan[i][2]);
            repeat (4) @(negedge sys_clk);
        end
        // Single-location writes: only the first beat lands
        ctl.setup(12'h222);
        ctl.wr(4, 4, 16'hB000);
        exp_mem[4] = 16'hB004;
        repeat (3) @(negedge sys_clk);
        rd(4, 4, 4, 0, 2);
        repeat (4) @(negedge sys_clk);
        // A test mode must refuse the read
        ctl.setup(12'h0A2);
        check("normal", {15'h0000, normal}, 16'h0000);
        ctl.cmd(`SDBM_CMD_RD, 2'h0, 12'h004);
        for (int k = 0; k < 4; k++)
        begin
            check("quiet", {15'h0000, dq_oe}, 16'h0000);
            @(negedge sys_clk);
        end
        results();
    end
endmodule // test_sdbm_core
